// file: hdl/usbi_pkg.sv
// package: register map, field layout and sizes of the iso endpoint block
package usbi_pkg;
   localparam logic [7:0] OFS_EP7 = 8'h00;
   localparam logic [7:0] OFS_EP8 = 8'h04;
   localparam logic [7:0] OFS_EP9 = 8'h08;
   localparam logic [7:0] OFS_ISTAT = 8'h0C;
   localparam logic [7:0] OFS_IMASK = 8'h10;
   // ep8 fields
   localparam int B8_TSP = 7;
   localparam int B8_TUR = 3;
   localparam int B8_FTF = 2;
   localparam int B8_TPC = 1;
   localparam int B8_TFS = 0;
   // ep9 fields
   localparam int B9_RSP = 7;
   localparam int B9_RNE = 6;
   localparam int B9_ROF = 2;
   localparam int B9_RPC = 1;
   localparam int B9_RFS = 0;
   // ep7 fields
   localparam int B7_RPC = 1;
   localparam int B7_RFS = 0;
   // interrupt status / mask fields
   localparam int BI_EP7 = 0;
   localparam int BI_EP8 = 1;
   localparam int BI_EP9 = 2;
   localparam logic [2:0] ISTAT_RST = 3'h0;
   localparam logic [2:0] IMASK_RST = 3'h0;
   // packet sizes
   localparam logic [8:0] ISO_PKT_BYTES = 9'h100;
   localparam logic [8:0] NAK_TRIG_BYTES = 9'h040;
   localparam logic [1:0] TFS_MAX_PKTS = 2'h1;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } usbi_req_t;

   typedef struct packed {
      logic [1:0] trig;
      logic [1:0][8:0] cnt;
      logic [1:0] shrt;
      logic wsel;
      logic rsel;
      logic tx_short_flag;
      logic tx_underrun_flag;
      logic tx_done_flag;
   } usbi_tx_t;

   typedef struct packed {
      logic [1:0] full;
      logic [1:0][8:0] cnt;
      logic [1:0] shrt;
      logic wsel;
      logic rsel;
      logic rsp;
      logic rx_overflow_flag;
      logic rx_done_flag;
   } usbi_rx_t;

   typedef struct packed {
      usbi_tx_t tx;
      usbi_rx_t rx;
      logic rpc7;
      logic [2:0] istat;
      logic [2:0] imask;
      logic irq;
      logic [31:0] rdata;
   } usbi_state_t;
endpackage

// file: hdl/usbi_csr.sv
// iso in/out endpoint control and status with bulk out low bits and irq
//
// The implementer's own choices: the strobed register port and the address map.
module usbi_csr
   import usbi_pkg::*;
(
   input wire logic MCLK,
   input wire logic SRST,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   input wire logic TX_LOAD,
   input wire logic TX_SENT,
   input wire logic TX_UNDERRUN,
   input wire logic IN_TOKEN,
   input wire logic CFG_RESET,
   output logic IN_NAK,
   output logic TX_FLUSH,
   input wire logic RX_PKT,
   input wire logic [8:0] RX_LEN,
   input wire logic RX_POP,
   input wire logic EP7_PKT,
   input wire logic EP7_AVAIL,
   output logic IRQ
);
   usbi_state_t s;
   usbi_state_t next_s;
   usbi_req_t req;
   logic wr8;
   logic wr9;
   logic wr7;
   logic wri;
   logic flush;
   logic tx_load_ok;
   logic tx_sent_ok;
   logic nak_trig;
   logic [1:0] pkts;
   logic rx_drop;
   logic rx_take;
   logic rx_drain;
   logic rx_zero_rel;
   logic rx_not_empty_flag;
   logic rx_service_flag;
   logic ev7;
   logic ev8;
   logic ev9;
   logic [2:0] ev;
   logic [7:0] r7;
   logic [7:0] r8;
   logic [7:0] r9;

   assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
   assign wr7 = req.wr && req.addr == OFS_EP7;
   assign wr8 = req.wr && req.addr == OFS_EP8;
   assign wr9 = req.wr && req.addr == OFS_EP9;
   assign wri = req.wr && req.addr == OFS_ISTAT;

   // flush: one-cycle action, never stored, so the bit reads zero
   assign flush = (wr8 && req.wdata[B8_FTF]) || CFG_RESET;
   assign TX_FLUSH = flush;

   // bytes into a buffer that is already triggered are dropped
   assign tx_load_ok = TX_LOAD && !s.tx.trig[s.tx.wsel];
   assign tx_sent_ok = TX_SENT && s.tx.trig[s.tx.rsel];
   assign pkts = {1'b0, s.tx.trig[0]} + {1'b0, s.tx.trig[1]};

   // a buffer counts as armed for the nak test once 64 bytes sit in it
   assign nak_trig = s.tx.trig[0] || s.tx.trig[1]
      || s.tx.cnt[0] >= NAK_TRIG_BYTES
      || s.tx.cnt[1] >= NAK_TRIG_BYTES;
   assign IN_NAK = IN_TOKEN && s.tx.tx_done_flag && !nak_trig;

   assign rx_drop = RX_PKT && s.rx.full[s.rx.wsel];
   assign rx_take = RX_PKT && !s.rx.full[s.rx.wsel];
   assign rx_drain = RX_POP && s.rx.full[s.rx.rsel]
      && s.rx.cnt[s.rx.rsel] == 9'h001;
   // a zero length packet has no bytes to read, so clearing done frees it
   assign rx_zero_rel = wr9 && req.wdata[B9_RPC]
      && s.rx.full[s.rx.rsel] && s.rx.cnt[s.rx.rsel] == 9'h000;
   assign rx_not_empty_flag = s.rx.full[s.rx.rsel] && s.rx.cnt[s.rx.rsel] != 9'h000;
   assign rx_service_flag = s.rx.full[0] || s.rx.full[1];

   assign ev8 = tx_sent_ok || TX_UNDERRUN;
   assign ev9 = rx_take || rx_drop;
   assign ev7 = EP7_PKT;
   assign ev = {ev9, ev8, ev7};

   always_comb
   begin
      r8 = 8'h00;
      r8[B8_TSP] = s.tx.tx_short_flag;
      r8[B8_TUR] = s.tx.tx_underrun_flag;
      r8[B8_TPC] = s.tx.tx_done_flag;
      r8[B8_TFS] = pkts <= TFS_MAX_PKTS;
      r9 = 8'h00;
      r9[B9_RSP] = s.rx.rsp;
      r9[B9_RNE] = rx_not_empty_flag;
      r9[B9_ROF] = s.rx.rx_overflow_flag;
      r9[B9_RPC] = s.rx.rx_done_flag;
      r9[B9_RFS] = rx_service_flag;
      r7 = 8'h00;
      r7[B7_RPC] = s.rpc7;
      r7[B7_RFS] = EP7_AVAIL;
   end

   always_comb
   begin
      next_s = s;
      // transmit side, two alternating buffers
      if (tx_load_ok)
      begin
         next_s.tx.cnt[s.tx.wsel] = s.tx.cnt[s.tx.wsel] + 9'h001;
         if (s.tx.cnt[s.tx.wsel] == ISO_PKT_BYTES - 9'h001)
         begin
            next_s.tx.trig[s.tx.wsel] = 1'b1;
            next_s.tx.wsel = !s.tx.wsel;
         end
      end
      // short flag arms the fill buffer; software can only set it
      if (wr8 && req.wdata[B8_TSP] && !s.tx.trig[s.tx.wsel])
      begin
         next_s.tx.tx_short_flag = 1'b1;
         next_s.tx.shrt[s.tx.wsel] = 1'b1;
         next_s.tx.trig[s.tx.wsel] = 1'b1;
         next_s.tx.wsel = !s.tx.wsel;
      end
      if (tx_sent_ok)
      begin
         next_s.tx.trig[s.tx.rsel] = 1'b0;
         next_s.tx.cnt[s.tx.rsel] = 9'h000;
         next_s.tx.shrt[s.tx.rsel] = 1'b0;
         next_s.tx.rsel = !s.tx.rsel;
         if (s.tx.shrt[s.tx.rsel] && !s.tx.shrt[!s.tx.rsel])
            next_s.tx.tx_short_flag = 1'b0;
      end
      // a short write in the cycle of the send arms a new buffer: set wins
      if (wr8 && req.wdata[B8_TSP] && !s.tx.trig[s.tx.wsel])
         next_s.tx.tx_short_flag = 1'b1;
      // set wins over the write-one clear for both flags
      if (wr8 && req.wdata[B8_TPC])
         next_s.tx.tx_done_flag = 1'b0;
      if (tx_sent_ok)
         next_s.tx.tx_done_flag = 1'b1;
      if (wr8 && req.wdata[B8_TUR])
         next_s.tx.tx_underrun_flag = 1'b0;
      if (TX_UNDERRUN)
         next_s.tx.tx_underrun_flag = 1'b1;
      if (flush)
      begin
         next_s.tx.trig = 2'h0;
         next_s.tx.cnt = '0;
         next_s.tx.shrt = 2'h0;
         next_s.tx.wsel = 1'b0;
         next_s.tx.rsel = 1'b0;
         next_s.tx.tx_short_flag = 1'b0;
      end

      // receive side, two alternating buffers
      if (RX_POP && rx_not_empty_flag)
         next_s.rx.cnt[s.rx.rsel] = s.rx.cnt[s.rx.rsel] - 9'h001;
      if (rx_drain || rx_zero_rel)
      begin
         next_s.rx.full[s.rx.rsel] = 1'b0;
         next_s.rx.shrt[s.rx.rsel] = 1'b0;
         next_s.rx.rsel = !s.rx.rsel;
         next_s.rx.rsp = s.rx.full[!s.rx.rsel]
            && s.rx.shrt[!s.rx.rsel];
      end
      if (rx_take)
      begin
         next_s.rx.full[s.rx.wsel] = 1'b1;
         next_s.rx.cnt[s.rx.wsel] = RX_LEN;
         next_s.rx.shrt[s.rx.wsel] = RX_LEN < ISO_PKT_BYTES;
         next_s.rx.wsel = !s.rx.wsel;
         // an arrival into an empty fifo becomes the active buffer
         if (!rx_service_flag)
            next_s.rx.rsp = RX_LEN < ISO_PKT_BYTES;
         else
            next_s.rx.rsp = 1'b0;
      end
      if (wr9 && req.wdata[B9_RPC])
         next_s.rx.rx_done_flag = 1'b0;
      if (rx_take)
         next_s.rx.rx_done_flag = 1'b1;
      if (wr9 && req.wdata[B9_ROF])
         next_s.rx.rx_overflow_flag = 1'b0;
      if (rx_drop)
         next_s.rx.rx_overflow_flag = 1'b1;

      // bulk out endpoint done flag
      if (wr7 && req.wdata[B7_RPC])
         next_s.rpc7 = 1'b0;
      if (EP7_PKT)
         next_s.rpc7 = 1'b1;

      // interrupt bits set only while enabled; cleared separately by one
      if (wri)
         next_s.istat = s.istat & ~req.wdata[2:0];
      next_s.istat = next_s.istat | (ev & s.imask);
      if (req.wr && req.addr == OFS_IMASK)
         next_s.imask = req.wdata[2:0];
      next_s.irq = |(next_s.istat & next_s.imask);

      // read data stands only in the cycle after the strobe
      next_s.rdata = 32'h0000_0000;
      if (req.rd)
      begin
         unique case (req.addr)
            OFS_EP7: next_s.rdata = {24'h000000, r7};
            OFS_EP8: next_s.rdata = {24'h000000, r8};
            OFS_EP9: next_s.rdata = {24'h000000, r9};
            OFS_ISTAT: next_s.rdata = {29'h0, s.istat};
            OFS_IMASK: next_s.rdata = {29'h0, s.imask};
            default: next_s.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge MCLK)
   begin
      if (SRST)
      begin
         s <= '0;
         s.istat <= ISTAT_RST;
         s.imask <= IMASK_RST;
      end
      else
         s <= next_s;
   end

   assign RDATA = s.rdata;
   assign IRQ = s.irq;
endmodule

// file: verif/usbi_host_model.sv
// host side model: token, sent, packet, config and underrun events
module usbi_host_model
(
   input wire logic mclk,
   input wire logic in_nak,
   output logic [4:0] ev,
   output logic [8:0] rx_len
);
   timeunit 1ns;
   timeprecision 100ps;
   initial {ev, rx_len} = {5'h0, 9'h1FF};
   // host keeps sending whether or not the device has room
   task go(input logic [4:0] v, input logic [8:0] l, output logic n);
      @(posedge mclk);
      {ev, rx_len} <= {v, l};
      #1 n = in_nak;
      @(posedge mclk);
      {ev, rx_len} <= {5'h0, ~l};
   endtask
endmodule

// file: verif/usbi_csr_assertions.sv
// checker: port relations of the iso endpoint block
module usbi_csr_assertions
   import usbi_pkg::*;
(
   input wire logic MCLK,
   input wire logic SRST,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   input wire logic IN_TOKEN,
   input wire logic CFG_RESET,
   input wire logic IN_NAK,
   input wire logic TX_FLUSH,
   input wire logic RX_PKT,
   input wire logic TX_UNDERRUN,
   input wire logic EP7_AVAIL,
   input wire logic IRQ
);
   logic [2:0] mk;
   always_ff @(posedge MCLK)
      if (SRST)
         mk <= 3'h0;
      else if (WR && ADDR == OFS_IMASK)
         mk <= WDATA[2:0];
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (SRST);
   sequence s_irq; ##1 IRQ; endsequence
   sequence s_rd(a); $past(RD) && $past(ADDR) == a; endsequence
   AST_FLUSH: assert property (TX_FLUSH == (CFG_RESET || WR
      && ADDR == OFS_EP8 && WDATA[B8_FTF])) else $error("flush");
   AST_NAK: assert property (IN_NAK |-> IN_TOKEN)
      else $error("nak");
   AST_EP8: assert property (s_rd(OFS_EP8) |-> RDATA[31:8] == 0
      && RDATA[6:4] == 3'h0 && !RDATA[B8_FTF]) else $error("ep8");
   AST_EP9: assert property (s_rd(OFS_EP9) |-> RDATA[31:8] == 0
      && RDATA[5:3] == 3'h0) else $error("ep9");
   AST_EP7: assert property (s_rd(OFS_EP7) |-> RDATA[31:2] == 0
      && RDATA[B7_RFS] == $past(EP7_AVAIL)) else $error("ep7");
   AST_RXIRQ: assert property (RX_PKT && mk[BI_EP9] && !WR
      |=> s_irq) else $error("rx irq");
   AST_TURIRQ: assert property (TX_UNDERRUN && mk[BI_EP8] && !WR
      |=> s_irq) else $error("tur irq");
   AST_IRQOFF: assert property (IRQ |-> (mk | $past(mk)) != 3'h0)
      else $error("irq");
endmodule
bind usbi_csr usbi_csr_assertions chk (.*);

// file: verif/usbi_csr_tb.sv
// self-checking bench of the iso endpoint control block
module usbi_csr_tb
   import usbi_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [4:0] SENT = 5'h10, TOK = 5'h08, PKT = 5'h04;
   localparam logic [4:0] CFG = 5'h02, TX_UNDERRUN_FLAG = 5'h01;
   logic mclk = 0, srst = 1, wr = 0, rd = 0, ld = 0, pop = 0, e7p = 0;
   logic e7a = 0, irq, nak, flush, fl, n;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [4:0] ev;
   logic [8:0] len;
   int n_errors = 0, n_compared = 0, k;
   usbi_csr DUT (.MCLK(mclk), .SRST(srst), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .TX_LOAD(ld), .TX_SENT(ev[4]),
      .TX_UNDERRUN(ev[0]), .IN_TOKEN(ev[3]), .CFG_RESET(ev[1]),
      .IN_NAK(nak), .TX_FLUSH(flush), .RX_PKT(ev[2]), .RX_LEN(len),
      .RX_POP(pop), .EP7_PKT(e7p), .EP7_AVAIL(e7a), .IRQ(irq));
   usbi_host_model host (.mclk(mclk), .in_nak(nak), .ev(ev), .rx_len(len));
   initial forever #20 mclk = ~mclk;
   function automatic logic [31:0] e8(logic s, u, d, f);
      return {24'h0, s, 3'h0, u, 1'b0, d, f};
   endfunction
   function automatic logic [31:0] e9(logic s, e, o, d, f);
      return {24'h0, s, e, 3'h0, o, d, f};
   endfunction
   task c(string s, logic [31:0] e, g);
      n_compared++;
      if (g !== e)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask
   task w(logic [7:0] a, logic [31:0] d);
      @(posedge mclk);
      {wr, addr, wdata} <= {1'b1, a, d};
      #1 fl = flush;
      @(posedge mclk);
      wr <= 0;
   endtask
   task r(logic [7:0] a, logic [31:0] e);
      @(posedge mclk);
      {rd, addr} <= {1'b1, a};
      @(posedge mclk);
      rd <= 0;
      #1 c($sformatf("reg %h", a), e, rdata);
   endtask
   // back-to-back byte pulses: p selects pop over load
   task b(logic p, int m);
      repeat (m) @(posedge mclk) {pop, ld} <= {p, !p};
      @(posedge mclk);
      {pop, ld} <= 2'b00;
   endtask
   task h(logic [4:0] v, logic [8:0] l = 9'h0);
      host.go(v, l, n);
   endtask
   task report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      #200us;
      n_errors++;
      report_and_stop();
   end
   initial
   begin
      k = $urandom(32'hd42c);
      repeat (8) @(posedge mclk);
      srst <= 0;
      r(OFS_EP8, e8(0, 0, 0, 1));
      r(OFS_EP9, 32'h0);
      r(OFS_EP7, 32'h0);
      r(8'h14, 32'h0);
      w(OFS_IMASK, 32'h7);
      $display("test reset done");
      b(0, 256);
      r(OFS_EP8, e8(0, 0, 0, 1));
      w(OFS_EP8, 32'h80);
      r(OFS_EP8, e8(1, 0, 0, 0));
      h(SENT);
      r(OFS_EP8, e8(1, 0, 1, 1));
      c("irq", 1, irq);
      h(TOK);
      c("nak", 0, n);
      h(SENT);
      r(OFS_EP8, e8(0, 0, 1, 1));
      h(TOK);
      c("nak", 1, n);
      k = $urandom_range(63, 1);
      b(0, k);
      h(TOK);
      c("nak", 1, n);
      b(0, 64 - k);
      h(TOK);
      c("nak", 0, n);
      w(OFS_EP8, 32'h04);
      c("flush", 1, fl);
      h(TOK);
      c("nak", 1, n);
      b(0, 64);
      h(CFG);
      h(TOK);
      c("nak", 1, n);
      w(OFS_EP8, 32'h02);
      r(OFS_EP8, e8(0, 0, 0, 1));
      c("irq", 1, irq);
      w(OFS_ISTAT, 32'h2);
      h(TX_UNDERRUN_FLAG);
      r(OFS_EP8, e8(0, 1, 0, 1));
      w(OFS_EP8, 32'h08);
      w(OFS_ISTAT, 32'h2);
      r(OFS_EP8, e8(0, 0, 0, 1));
      c("irq", 0, irq);
      $display("test tx done");
      w(OFS_IMASK, 32'h6);
      @(posedge mclk) {e7a, e7p} <= 2'b11;
      @(posedge mclk) e7p <= 0;
      r(OFS_EP7, 32'h3);
      r(OFS_ISTAT, 32'h0);
      w(OFS_EP7, 32'h2);
      r(OFS_EP7, 32'h1);
      k = $urandom_range(8, 1);
      h(PKT, 9'(k));
      r(OFS_EP9, e9(1, 1, 0, 1, 1));
      c("irq", 1, irq);
      h(PKT, 9'h100);
      h(PKT, 9'h100);
      r(OFS_EP9, e9(0, 1, 1, 1, 1));
      b(1, k);
      r(OFS_EP9, e9(0, 1, 1, 1, 1));
      b(1, 256);
      r(OFS_EP9, e9(0, 0, 1, 1, 0));
      w(OFS_EP9, 32'h6);
      h(PKT, 9'h0);
      r(OFS_EP9, e9(1, 0, 0, 1, 1));
      $display("test rx done");
      report_and_stop();
   end
endmodule
